// ### design/plm_axil_slave.sv
`timescale 1ns/1ps
module plm_axil_slave
   import plm_pkg::*;
(
   input  wire logic          clock,
   input  wire logic          arst_n,
   input  wire logic [AW-1:0] awaddr,
   input  wire logic          awvalid,
   output logic               awready,
   input  wire logic [31:0]   wdata,
   input  wire logic [3:0]    wstrb,
   input  wire logic          wvalid,
   output logic               wready,
   output logic [1:0]         bresp,
   output logic               bvalid,
   input  wire logic          bready,
   input  wire logic [AW-1:0] araddr,
   input  wire logic          arvalid,
   output logic               arready,
   output logic [31:0]        rdata,
   output logic [1:0]         rresp,
   output logic               rvalid,
   input  wire logic          rready,
   plm_reg_if.slv             rif
);
   logic rd_pend_q;

   assign rif.wr_en = ~awready & ~wready & ~bvalid;
   assign rif.rd_en = rd_pend_q;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         awready     <= 1'b1;
         rif.wr_addr <= '0;
      end else if (awvalid && awready) begin
         awready     <= 1'b0;
         rif.wr_addr <= {awaddr[AW-1:2], 2'b00};
      end else if (bvalid && bready) begin
         awready <= 1'b1;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wready      <= 1'b1;
         rif.wr_data <= '0;
         rif.wr_strb <= '0;
      end else if (wvalid && wready) begin
         wready      <= 1'b0;
         rif.wr_data <= wdata;
         rif.wr_strb <= wstrb;
      end else if (bvalid && bready) begin
         wready <= 1'b1;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end else if (rif.wr_en) begin
         bvalid <= 1'b1;
         bresp  <= rif.wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
         bvalid <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         arready     <= 1'b1;
         rd_pend_q   <= 1'b0;
         rif.rd_addr <= '0;
         rvalid      <= 1'b0;
         rdata       <= '0;
         rresp       <= RESP_OKAY;
      end else begin
         rd_pend_q <= 1'b0;
         if (arvalid && arready) begin
            arready     <= 1'b0;
            rd_pend_q   <= 1'b1;
            rif.rd_addr <= {araddr[AW-1:2], 2'b00};
         end
         if (rd_pend_q) begin
            rvalid <= 1'b1;
            rdata  <= rif.rd_ok ? rif.rd_data : 32'h0000_0000;
            rresp  <= rif.rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
         end
      end
   end
endmodule : plm_axil_slave

// ### design/plm_cell.sv
`timescale 1ns/1ps
module plm_cell
   import plm_pkg::*;
(
   input  wire logic clock,
   input  wire logic arst_n,
   input  wire logic ar_term,
   input  wire logic sp_term,
   input  wire logic sum,
   input  wire logic oe_term,
   input  wire logic reg_mode,
   input  wire logic in_mode,
   input  wire logic pin_s,
   output logic      out_q,
   output logic      oe_n_q,
   output logic      fb
);
   logic clr_n;

   // Global clear only reaches registered cells
   assign clr_n = arst_n & ~(ar_term & reg_mode);

   always_ff @(posedge clock or negedge clr_n) begin
      if (!clr_n) begin
         out_q <= 1'b0;
      end else if (reg_mode && sp_term) begin
         out_q <= 1'b1;
      end else begin
         out_q <= sum;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         oe_n_q <= 1'b1;
      end else begin
         oe_n_q <= ~(oe_term & ~in_mode);
      end
   end

   assign fb = in_mode ? pin_s : out_q;
endmodule : plm_cell

// ### design/plm_top.sv
`timescale 1ns/1ps
module plm_top
   import plm_pkg::*;
(
   input  wire logic             clock,
   input  wire logic             arst_n,
   input  wire logic [AW-1:0]    s_axi_awaddr,
   input  wire logic             s_axi_awvalid,
   output logic                  s_axi_awready,
   input  wire logic [31:0]      s_axi_wdata,
   input  wire logic [3:0]       s_axi_wstrb,
   input  wire logic             s_axi_wvalid,
   output logic                  s_axi_wready,
   output logic [1:0]            s_axi_bresp,
   output logic                  s_axi_bvalid,
   input  wire logic             s_axi_bready,
   input  wire logic [AW-1:0]    s_axi_araddr,
   input  wire logic             s_axi_arvalid,
   output logic                  s_axi_arready,
   output logic [31:0]           s_axi_rdata,
   output logic [1:0]            s_axi_rresp,
   output logic                  s_axi_rvalid,
   input  wire logic             s_axi_rready,
   input  wire logic [NDIN-1:0]  din_i,
   input  wire logic [NCELL-1:0] pin_i,
   output logic [NCELL-1:0]      pin_o,
   output logic [NCELL-1:0]      pin_oe_n
);
   plm_reg_if rif ();

   logic [31:0]      tmask_q [NTERM];
   logic [31:0]      cmask_q [NTERM];
   logic [CFG_W-1:0] cfg_q   [NCELL];
   logic [NDIN-1:0]  din_m_q;
   logic [NDIN-1:0]  din_s_q;
   logic [NCELL-1:0] pin_m_q;
   logic [NCELL-1:0] pin_s_q;
   logic [NCELL-1:0] fb;
   logic [NARR-1:0]  arr_in;
   logic [NTERM-1:0] pterm;
   logic [NCELL-1:0] sum;
   logic [NCELL-1:0] oe_term;
   logic [NCELL-1:0] reg_mode;
   logic [NCELL-1:0] in_mode;
   logic             ar_term;
   logic             sp_term;
   logic             wr_term;
   logic             wr_cfg;
   logic [4:0]       wr_tidx;
   logic [3:0]       wr_cidx;
   logic [4:0]       rd_tidx;
   logic [3:0]       rd_cidx;

   plm_axil_slave u_slave (
      .clock   (clock),
      .arst_n  (arst_n),
      .awaddr  (s_axi_awaddr),
      .awvalid (s_axi_awvalid),
      .awready (s_axi_awready),
      .wdata   (s_axi_wdata),
      .wstrb   (s_axi_wstrb),
      .wvalid  (s_axi_wvalid),
      .wready  (s_axi_wready),
      .bresp   (s_axi_bresp),
      .bvalid  (s_axi_bvalid),
      .bready  (s_axi_bready),
      .araddr  (s_axi_araddr),
      .arvalid (s_axi_arvalid),
      .arready (s_axi_arready),
      .rdata   (s_axi_rdata),
      .rresp   (s_axi_rresp),
      .rvalid  (s_axi_rvalid),
      .rready  (s_axi_rready),
      .rif     (rif)
   );

   // Pin synchronisers
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         din_m_q <= '0;
         din_s_q <= '0;
         pin_m_q <= '0;
         pin_s_q <= '0;
      end else begin
         din_m_q <= din_i;
         din_s_q <= din_m_q;
         pin_m_q <= pin_i;
         pin_s_q <= pin_m_q;
      end
   end

   // Register decode
   assign wr_tidx = rif.wr_addr[7:3];
   assign wr_cidx = rif.wr_addr[5:2];
   assign rd_tidx = rif.rd_addr[7:3];
   assign rd_cidx = rif.rd_addr[5:2];
   assign wr_term = rif.wr_addr <= TERM_LAST;
   assign wr_cfg  = rif.wr_addr >= CFG_BASE && rif.wr_addr <= CFG_LAST;
   assign rif.wr_ok = wr_term | wr_cfg;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         for (int t = 0; t < NTERM; t++) begin
            tmask_q[t] <= TERM_RST;
            cmask_q[t] <= TERM_RST;
         end
      end else if (rif.wr_en && wr_term) begin
         if (rif.wr_addr[2]) begin
            cmask_q[wr_tidx] <= plm_merge(cmask_q[wr_tidx], rif.wr_data, rif.wr_strb);
         end else begin
            tmask_q[wr_tidx] <= plm_merge(tmask_q[wr_tidx], rif.wr_data, rif.wr_strb);
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         for (int c = 0; c < NCELL; c++) begin
            cfg_q[c] <= CFG_RST;
         end
      end else if (rif.wr_en && wr_cfg && rif.wr_strb[0]) begin
         cfg_q[wr_cidx] <= rif.wr_data[CFG_W-1:0];
      end
   end

   always_comb begin
      rif.rd_data = 32'h0000_0000;
      rif.rd_ok   = 1'b1;
      if (rif.rd_addr <= TERM_LAST) begin
         rif.rd_data = rif.rd_addr[2] ? cmask_q[rd_tidx] : tmask_q[rd_tidx];
      end else if (rif.rd_addr >= CFG_BASE && rif.rd_addr <= CFG_LAST) begin
         rif.rd_data[CFG_W-1:0] = cfg_q[rd_cidx];
      end else if (rif.rd_addr == PIN_STAT) begin
         rif.rd_data[NCELL-1:0] = pin_s_q;
         rif.rd_data[16 +: NDIN] = din_s_q;
      end else if (rif.rd_addr == OUT_STAT) begin
         rif.rd_data[NCELL-1:0] = pin_o;
         rif.rd_data[16 +: NCELL] = ~pin_oe_n;
      end else if (rif.rd_addr == TERM_STAT) begin
         rif.rd_data = pterm;
      end else begin
         rif.rd_ok = 1'b0;
      end
   end

   // Logic array: dedicated inputs plus every cell's feedback
   assign arr_in = {fb, din_s_q};

   always_comb begin
      for (int t = 0; t < NTERM; t++) begin
         pterm[t] = plm_term(tmask_q[t], cmask_q[t], arr_in);
      end
   end

   // Global terms use none of the cells' own terms
   assign ar_term = pterm[AR_TERM];
   assign sp_term = pterm[SP_TERM];

   for (genvar c = 0; c < NCELL; c++) begin : g_cell
      assign sum[c]      = pterm[TPC*c] | pterm[TPC*c+1];
      assign oe_term[c]  = pterm[TPC*c+2];
      assign reg_mode[c] = cfg_q[c][CFG_REG_BIT];
      assign in_mode[c]  = cfg_q[c][CFG_IN_BIT];

      plm_cell u_cell (
         .clock    (clock),
         .arst_n   (arst_n),
         .ar_term  (ar_term),
         .sp_term  (sp_term),
         .sum      (sum[c]),
         .oe_term  (oe_term[c]),
         .reg_mode (reg_mode[c]),
         .in_mode  (in_mode[c]),
         .pin_s    (pin_s_q[c]),
         .out_q    (pin_o[c]),
         .oe_n_q   (pin_oe_n[c]),
         .fb       (fb[c])
      );

      a_cell_oe_on: assert property (@(posedge clock) disable iff (!arst_n)
         oe_term[c] && !in_mode[c] |=> !pin_oe_n[c])
         else $error("cell output enable not taken");

      a_input_mode_off: assert property (@(posedge clock) disable iff (!arst_n)
         in_mode[c] ##1 in_mode[c] |-> pin_oe_n[c] && fb[c] == pin_s_q[c])
         else $error("input-mode pin driven or feedback wrong");

      a_feedback_out: assert property (@(posedge clock) disable iff (!arst_n)
         !in_mode[c] |-> fb[c] == pin_o[c])
         else $error("cell feedback differs from output");

      a_comb_follows: assert property (@(posedge clock) disable iff (!arst_n)
         !reg_mode[c] ##1 !reg_mode[c] |-> pin_o[c] == $past(sum[c]))
         else $error("combinational cell not following its sum");

      a_reset_clears: assert property (@(posedge clock) disable iff (!arst_n)
         ar_term && reg_mode[c] |-> !pin_o[c])
         else $error("registered cell not cleared by global reset");

      a_reset_beats: assert property (@(posedge clock) disable iff (!arst_n)
         ar_term && sp_term && reg_mode[c] ##1 reg_mode[c] |-> !pin_o[c])
         else $error("preset won over reset");

      a_cell_oe_off: assert property (@(posedge clock) disable iff (!arst_n)
         !oe_term[c] || in_mode[c] |=> pin_oe_n[c])
         else $error("cell driving without its enable term");

      a_reg_takes_sum: assert property (@(posedge clock) disable iff (!arst_n)
         reg_mode[c] && !sp_term && !ar_term ##1 !ar_term |-> pin_o[c] == $past(sum[c]))
         else $error("registered cell not loading its sum");
   end

   a_preset_all: assert property (@(posedge clock) disable iff (!arst_n)
      sp_term && !ar_term ##1 !ar_term |-> (pin_o & $past(reg_mode)) == $past(reg_mode))
      else $error("registered cells not all preset");

   a_reset_all: assert property (@(posedge clock) disable iff (!arst_n)
      ar_term |-> (pin_o & reg_mode) == '0)
      else $error("registered cells not all cleared");

   a_preset_sets: assert property (@(posedge clock) disable iff (!arst_n)
      sp_term && !ar_term && reg_mode[9] ##1 !ar_term && reg_mode[9] |-> pin_o[9])
      else $error("registered cell not preset");

   a_tenth_drives: assert property (@(posedge clock) disable iff (!arst_n)
      oe_term[9] && !in_mode[9] ##1 oe_term[9] && !in_mode[9] |-> !pin_oe_n[9] ##1 !pin_oe_n[9])
      else $error("tenth cell not driving");

   a_global_from_array: assert property (@(posedge clock) disable iff (!arst_n)
      tmask_q[AR_TERM] == 32'h0000_0000 |-> !ar_term)
      else $error("global reset fired while unprogrammed");

   c_reset_fire: cover property (@(posedge clock) disable iff (!arst_n)
      ar_term && reg_mode[0]);
   c_preset_fire: cover property (@(posedge clock) disable iff (!arst_n)
      sp_term && !ar_term && reg_mode[0] ##1 pin_o[0]);
   c_dyn_io: cover property (@(posedge clock) disable iff (!arst_n)
      !pin_oe_n[1] ##1 pin_oe_n[1]);
   c_input_pin: cover property (@(posedge clock) disable iff (!arst_n)
      in_mode[2] && pin_s_q[2]);
endmodule : plm_top

// ### pkg/plm_pkg.sv
package plm_pkg;
   localparam int unsigned NCELL   = 10;
   localparam int unsigned NDIN    = 8;
   localparam int unsigned NARR    = NCELL + NDIN;
   localparam int unsigned TPC     = 3;
   localparam int unsigned NTERM   = 32;
   localparam int unsigned AR_TERM = 30;
   localparam int unsigned SP_TERM = 31;
   localparam int unsigned AW      = 12;

   // Byte addresses
   localparam logic [AW-1:0] TERM_BASE = 12'h000;
   localparam logic [AW-1:0] TERM_LAST = 12'h0fc;
   localparam logic [AW-1:0] CFG_BASE  = 12'h100;
   localparam logic [AW-1:0] CFG_LAST  = 12'h124;
   localparam logic [AW-1:0] PIN_STAT  = 12'h140;
   localparam logic [AW-1:0] OUT_STAT  = 12'h144;
   localparam logic [AW-1:0] TERM_STAT = 12'h148;

   // Field positions and reset values
   localparam int unsigned TERM_EN_BIT = 31;
   localparam int unsigned CFG_REG_BIT = 0;
   localparam int unsigned CFG_IN_BIT  = 1;
   localparam int unsigned CFG_W       = 2;
   localparam logic [31:0]      TERM_RST = 32'h0000_0000;
   localparam logic [CFG_W-1:0] CFG_RST  = 2'h0;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // One AND term: enable, true-literal mask, complement-literal mask
   function automatic logic plm_term(input logic [31:0] t, input logic [31:0] c,
                                     input logic [NARR-1:0] v);
      plm_term = t[TERM_EN_BIT] & (&((~t[NARR-1:0] | v) & (~c[NARR-1:0] | ~v)));
   endfunction : plm_term

   function automatic logic [31:0] plm_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      plm_merge = r;
   endfunction : plm_merge
endpackage : plm_pkg

// ### pkg/plm_reg_if.sv
`timescale 1ns/1ps
interface plm_reg_if;
   import plm_pkg::*;
   logic          wr_en;
   logic [AW-1:0] wr_addr;
   logic [31:0]   wr_data;
   logic [3:0]    wr_strb;
   logic          wr_ok;
   logic          rd_en;
   logic [AW-1:0] rd_addr;
   logic [31:0]   rd_data;
   logic          rd_ok;
   modport slv  (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                 input wr_ok, rd_data, rd_ok);
   modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                 output wr_ok, rd_data, rd_ok);
endinterface : plm_reg_if

// ### tb/plm_board.sv
`timescale 1ns/1ps
module plm_board
   import plm_pkg::*;
(
   input  wire logic [NCELL-1:0] pin_o,
   input  wire logic [NCELL-1:0] pin_oe_n,
   input  wire logic [NCELL-1:0] ext_en,
   input  wire logic [NCELL-1:0] ext_val,
   output logic      [NCELL-1:0] pin_i
);
   // Device level where driven, else board value, else pull-up
   always_comb begin
      for (int k = 0; k < NCELL; k++) begin
         pin_i[k] = !pin_oe_n[k] ? pin_o[k] : (ext_en[k] ? ext_val[k] : 1'b1);
      end
   end
endmodule : plm_board

// ### tb/plm_top_test.sv
`timescale 1ns/1ps
module plm_top_test;
   import plm_pkg::*;
   logic             clock, arst_n;
   logic [AW-1:0]    awaddr, araddr;
   logic             awvalid, wvalid, bready, arvalid, rready;
   logic             awready, wready, bvalid, arready, rvalid;
   logic [31:0]      wdata, rdata;
   logic [3:0]       wstrb;
   logic [1:0]       bresp, rresp;
   logic [NDIN-1:0]  din_i;
   logic [NCELL-1:0] pin_i, pin_o, pin_oe_n, ext_en, ext_val, p;
   logic [7:0]       d;
   logic [33:0]      exp_q[$];
   logic [7:0]       seq[4] = '{8'h80, 8'h00, 8'h80, 8'hc0};
   int               mismatches, total_checks;

   plm_top i_plm_top (.clock(clock), .arst_n(arst_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .din_i(din_i), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(pin_oe_n));

   plm_board i_plm_board (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .ext_en(ext_en),
      .ext_val(ext_val), .pin_i(pin_i));

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   task automatic check(input logic [33:0] seen, input logic [33:0] expv);
      total_checks++;
      if (seen !== expv) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
      end
   endtask : check

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : conclude

   task automatic hang();
      mismatches++;
      conclude();
   endtask : hang

   task automatic wr(input logic [AW-1:0] a, input logic [31:0] dt, input logic [1:0] r);
      int n;
      bit done;
      n = 0;
      done = 0;
      exp_q.push_back({r, 32'h0});
      awaddr <= a;
      wdata <= dt;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done && n < 100) begin
         @(posedge clock);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            bready <= 1'b0;
            done = 1;
         end
      end
      if (!done) hang();
      @(posedge clock);
   endtask : wr

   task automatic rd(input logic [AW-1:0] a, input logic [31:0] expv, input logic [1:0] r);
      int n;
      bit done;
      n = 0;
      done = 0;
      exp_q.push_back({r, expv});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done && n < 100) begin
         @(posedge clock);
         n++;
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            rready <= 1'b0;
            done = 1;
         end
      end
      if (!done) hang();
      @(posedge clock);
   endtask : rd

   task automatic tw(input int t, input logic [31:0] v);
      wr(AW'(8 * t), v, RESP_OKAY);
   endtask : tw

   task automatic settle();
      repeat (10) @(posedge clock);
   endtask : settle

   // Takes the oldest note whenever a response is handed over
   always @(posedge clock) begin
      if ((rvalid && rready) || (bvalid && bready)) begin
         if (exp_q.size() == 0) mismatches++;
         else check((rvalid && rready) ? {rresp, rdata} : {bresp, 32'h0}, exp_q.pop_front());
      end
   end

   initial begin
      arst_n = 1'b0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = '0;
      din_i = '0;
      ext_en = '0;
      ext_val = '0;
      void'($urandom(32'h1b0b));
      repeat (16) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      for (int c = 0; c < NCELL; c++) rd(CFG_BASE + AW'(4 * c), 32'h0, RESP_OKAY);
      rd(TERM_BASE, 32'h0, RESP_OKAY);
      rd(OUT_STAT, 32'h0, RESP_OKAY);
      rd(12'h200, 32'h0, RESP_SLVERR);
      wr(TERM_STAT, 32'h1, RESP_SLVERR);
      rd(TERM_STAT, 32'h0, RESP_OKAY);
      $display("test reset done");
      // Combinational cells follow inputs, cell 9 follows cell 0
      for (int c = 0; c < NCELL; c++) begin
         tw(3 * c, 32'h8000_0000 | (c == 9 ? 32'h100 : 32'h1 << (c % 8)));
         tw(3 * c + 2, 32'h8000_0000);
      end
      repeat (3) begin
         d = 8'($urandom());
         din_i <= d;
         settle();
         p = {d[0], d[0], d};
         rd(OUT_STAT, {6'h0, 10'h3ff, 6'h0, p}, RESP_OKAY);
         rd(PIN_STAT, {8'h0, d, 6'h0, p}, RESP_OKAY);
      end
      $display("test combinational done");
      // Cell 2 as input, cell 3 fed from it
      wr(CFG_BASE + 12'h8, 32'h2, RESP_OKAY);
      tw(9, 32'h8000_0400);
      ext_en <= 10'h004;
      for (int v = 0; v < 2; v++) begin
         ext_val <= {NCELL{v[0]}};
         settle();
         check({33'h0, pin_oe_n[2]}, 34'h1);
         p = {d[0], d[0], d[7:4], v[0], v[0], d[1:0]};
         rd(PIN_STAT, {8'h0, d, 6'h0, p}, RESP_OKAY);
      end
      ext_en <= '0;
      $display("test input mode done");
      // Cell 1 enable from a complement literal, released pin pulled up
      wr(TERM_BASE + 12'h02c, 32'h0000_0020, RESP_OKAY);
      for (int v = 0; v < 2; v++) begin
         din_i <= {2'h0, v[0], 5'h0};
         settle();
         check({33'h0, pin_oe_n[1]}, {33'h0, v[0]});
         p = {4'h0, v[0], 3'h3, v[0], 1'b0};
         rd(PIN_STAT, {8'h0, 2'h0, v[0], 5'h0, 6'h0, p}, RESP_OKAY);
      end
      wr(TERM_BASE + 12'h02c, 32'h0, RESP_OKAY);
      $display("test enable term done");
      // Registered cells under global preset and reset terms
      for (int c = 0; c < NCELL; c++) begin
         wr(CFG_BASE + AW'(4 * c), 32'h1, RESP_OKAY);
         tw(3 * c, 32'h0);
      end
      tw(AR_TERM, 32'h8000_0040);
      tw(SP_TERM, 32'h8000_0080);
      for (int i = 0; i < 4; i++) begin
         din_i <= seq[i];
         settle();
         rd(OUT_STAT, {6'h0, 10'h3ff, 6'h0, (i % 2 == 0) ? 10'h3ff : 10'h0}, RESP_OKAY);
      end
      $display("test preset reset done");
      conclude();
   end

   initial begin
      repeat (60000) @(posedge clock);
      hang();
   end
endmodule : plm_top_test
